// ===== logic/ctx_save_restore.sv
// Purpose: two-level interrupt context store with peripheral flag register
// Assumes: core signals entry with priority and vector, exit with a pulse
// Notes: shadow copies live in a Wishbone-visible register set
// Functional notes
// - two saved levels, main and low routine
// - program counter goes to separate return stack
// - save status, work, bank, pointers, product, latches
// - load working register with vector after capture
// - choose level from state and delivery order
// - multi-vector setting does not change saving
// - priority disabled saves only main context
// - shadow set sits in bank 56
// - view select bit picks main or low
// - nested high routine exit restores low context
// - low routine exit restores main context
// - software writes to shadow are restored
// - flags set regardless of any enable
// - flag stays one until software clears
`timescale 1ns/10ps
`default_nettype none
module ctx_save_restore
  import ctx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // core context port
  input wire logic entry_i,
  input wire logic entry_high_i,
  input wire logic [7:0] vector_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic exit_i,
  input wire logic [8*SLOTS-1:0] cpu_ctx_i,
  output logic [8*SLOTS-1:0] restore_ctx_o,
  output logic restore_o,
  output logic [7:0] work_load_o,
  output logic work_load_en_o,
  output logic [PC_W-1:0] ret_pc_o,
  output logic [7:0] shadow_bank_o,
  // peripheral events
  input wire logic [7:0] periph_event_i,
  output logic [7:0] flags_o,
  // interrupt
  output logic irq_o
);

  logic [7:0] main_q [SLOTS];
  logic [7:0] low_q [SLOTS];
  level_t level_q;
  logic view_low_q;
  logic [1:0] cfg_q;
  logic [7:0] flags_q;
  logic [2:0] ev_q;
  logic [2:0] mask_q;
  logic [PC_W-1:0] ras_q [RAS_DEPTH];
  logic [2:0] ras_cnt_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] restore_q [SLOTS];
  logic restore_q_en;
  logic [7:0] work_q;
  logic work_en_q;

  logic wb_req;
  logic wb_wr;
  logic shadow_hit;
  logic [3:0] shadow_idx;
  logic save_main;
  logic save_low;
  logic ras_push;
  logic ras_pop;
  logic [2:0] ev_set;
  logic entry_take;
  logic ras_fault;

  function automatic logic [7:0] ctx_byte(input logic [8*SLOTS-1:0] v, input int unsigned i);
    ctx_byte = v[8*i +: 8];
  endfunction

  // register decode shared by the flag and status write paths
  function automatic logic reg_wr(input logic wr, input logic [7:0] adr, input logic [7:0] off);
    reg_wr = wr && adr == off;
  endfunction

  // a request is taken once; the registered ack blocks a second take
  assign wb_req = cyc_i & stb_i & ~ack_q;
  // writes land on the edge at which the master samples ack, never on the taking edge
  assign wb_wr = cyc_i & stb_i & ack_q & we_i & sel_i[0];
  // only the first thirteen word slots hold shadow bytes
  assign shadow_hit = adr_i < OFF_SHADOW_CTRL && adr_i[5:2] < 4'(SLOTS);
  assign shadow_idx = adr_i[5:2];

  // cfg_q[CFG_MVEC] is stored only; it never enters the save decision
  always_comb
  begin
    save_main = 1'b0;
    save_low = 1'b0;
    if (entry_i)
    begin
      case (level_q)
        LVL_MAIN: save_main = 1'b1;
        LVL_LOW: save_low = cfg_q[CFG_PRIO] & entry_high_i;
        default: save_main = 1'b0;
      endcase
    end
  end

  // level tracking follows the order of delivery to the core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_q <= LVL_MAIN;
    else if (entry_i)
    begin
      case (level_q)
        LVL_MAIN: level_q <= (cfg_q[CFG_PRIO] & entry_high_i) ? LVL_HIGH_DIRECT : LVL_LOW;
        // a nested entry that cannot preempt leaves the level alone
        LVL_LOW: level_q <= (cfg_q[CFG_PRIO] & entry_high_i) ? LVL_HIGH : LVL_LOW;
        default: level_q <= level_q;
      endcase
    end
    else if (exit_i)
    begin
      case (level_q)
        LVL_HIGH: level_q <= LVL_LOW;
        LVL_LOW: level_q <= LVL_MAIN;
        LVL_HIGH_DIRECT: level_q <= LVL_MAIN;
        default: level_q <= LVL_MAIN;
      endcase
    end
  end

  // both levels are banked copies of the full register set
  // a save and a software write to one slot in one cycle: the save wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        main_q[i] <= 8'h00;
        low_q[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        if (save_main)
          main_q[i] <= ctx_byte(cpu_ctx_i, i);
        else if (wb_wr && shadow_hit && !view_low_q && shadow_idx == 4'(i))
          main_q[i] <= dat_i[7:0];
        if (save_low)
          low_q[i] <= ctx_byte(cpu_ctx_i, i);
        else if (wb_wr && shadow_hit && view_low_q && shadow_idx == 4'(i))
          low_q[i] <= dat_i[7:0];
      end
    end
  end

  // working register gets the vector one cycle after capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      work_q <= 8'h00;
      work_en_q <= 1'b0;
    end
    else
    begin
      work_en_q <= entry_i;
      if (entry_i)
        work_q <= vector_i;
    end
  end

  // restore of the level below on exit, including any software edits
  // entry wins over exit when both arrive in one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      restore_q_en <= 1'b0;
      for (int i = 0; i < SLOTS; i++)
        restore_q[i] <= 8'h00;
    end
    else
    begin
      restore_q_en <= exit_i & ~entry_i & (level_q != LVL_MAIN);
      if (exit_i && !entry_i)
      begin
        for (int i = 0; i < SLOTS; i++)
          restore_q[i] <= (level_q == LVL_HIGH) ? low_q[i] : main_q[i];
      end
    end
  end

  // only an entry that opens a level pushes; an ignored nested one would unbalance the stack
  assign entry_take = entry_i
                      && (level_q == LVL_MAIN || (level_q == LVL_LOW && cfg_q[CFG_PRIO] && entry_high_i));
  // return stack is separate from the shadow set; overflow/underflow raise an event
  assign ras_push = entry_take && ras_cnt_q < 3'(RAS_DEPTH);
  assign ras_pop = exit_i && !entry_i && level_q != LVL_MAIN && ras_cnt_q != 3'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ras_cnt_q <= 3'h0;
      for (int i = 0; i < RAS_DEPTH; i++)
        ras_q[i] <= '0;
    end
    // the top entry sits at count minus one
    else if (ras_push)
    begin
      ras_q[ras_cnt_q[1:0]] <= pc_i;
      ras_cnt_q <= ras_cnt_q + 3'h1;
    end
    else if (ras_pop)
      ras_cnt_q <= ras_cnt_q - 3'h1;
  end

  // hardware set wins over a software clear in the same cycle
  // unimplemented bits are masked on every path, so they read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_q <= FLAGS_RESET;
    else if (reg_wr(wb_wr, adr_i, OFF_FLAGS))
      flags_q <= ((flags_q & dat_i[7:0]) | periph_event_i) & FLAG_IMPL;
    else
      flags_q <= (flags_q | periph_event_i) & FLAG_IMPL;
  end

  // a refused push or an exit with nothing to pop marks a stack fault
  assign ras_fault = (entry_take && !ras_push)
                     || (exit_i && !entry_i && level_q != LVL_MAIN && ras_cnt_q == 3'h0);
  assign ev_set = {ras_fault, restore_q_en, work_en_q};

  // status bits are sticky; a one written clears, a new event in the same cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ev_q <= EV_RESET;
    else if (reg_wr(wb_wr, adr_i, OFF_IRQ_STATUS))
      ev_q <= (ev_q & ~dat_i[2:0]) | ev_set;
    else
      ev_q <= ev_q | ev_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= EV_RESET;
      cfg_q <= CFG_RESET;
      view_low_q <= 1'b0;
    end
    // config bit1 is kept only for software to read back
    else if (wb_wr)
    begin
      if (adr_i == OFF_IRQ_MASK)
        mask_q <= dat_i[2:0];
      if (adr_i == OFF_CONFIG)
        cfg_q <= dat_i[1:0];
      if (adr_i == OFF_SHADOW_CTRL)
        view_low_q <= dat_i[0];
    end
  end

  // single-cycle answer; unmapped reads return zero and writes are dropped
  // read data is registered on the taking edge and stands with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req;
      rdat_q <= 32'h0000_0000;
      if (wb_req && !we_i)
      begin
        if (shadow_hit)
          rdat_q <= {24'h00_0000, view_low_q ? low_q[shadow_idx] : main_q[shadow_idx]};
        else
        begin
          case (adr_i)
            OFF_SHADOW_CTRL: rdat_q <= {31'h0, view_low_q};
            OFF_FLAGS: rdat_q <= {24'h00_0000, flags_q};
            OFF_IRQ_STATUS: rdat_q <= {29'h0, ev_q};
            OFF_IRQ_MASK: rdat_q <= {29'h0, mask_q};
            OFF_CONFIG: rdat_q <= {30'h0, cfg_q};
            OFF_STATE: rdat_q <= {27'h0, ras_cnt_q, level_q};
            OFF_RAS_TOP: rdat_q <= (ras_cnt_q == 3'h0) ? 32'h0 : {11'h0, ras_q[2'(ras_cnt_q - 3'h1)]};
            default: rdat_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // the popped return address stands until the next pop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ret_pc_o <= '0;
    else if (ras_pop)
      ret_pc_o <= ras_q[2'(ras_cnt_q - 3'h1)];
  end

  // flat view of the registered restore bytes, slot i in byte i
  always_comb
  begin
    for (int i = 0; i < SLOTS; i++)
      restore_ctx_o[8*i +: 8] = restore_q[i];
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;
  assign restore_o = restore_q_en;
  assign work_load_o = work_q;
  assign work_load_en_o = work_en_q;
  assign shadow_bank_o = SHADOW_BANK;
  assign flags_o = flags_q;
  // level output, high while any unmasked status bit is set
  assign irq_o = |(ev_q & mask_q);

endmodule
`default_nettype wire

// ===== logic/ctx_pkg.sv
// Purpose: constants and types for the interrupt context save/restore block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: shadow set sits at word offsets in a small local map
package ctx_pkg;
  localparam int unsigned CTX_N = 11;
  // context slot indices
  localparam logic [3:0] SLOT_STATUS = 4'h0;
  localparam logic [3:0] SLOT_WORK = 4'h1;
  localparam logic [3:0] SLOT_BANK = 4'h2;
  localparam logic [3:0] SLOT_FSR0L = 4'h3;
  localparam logic [3:0] SLOT_FSR0H = 4'h4;
  localparam logic [3:0] SLOT_FSR1L = 4'h5;
  localparam logic [3:0] SLOT_FSR1H = 4'h6;
  localparam logic [3:0] SLOT_FSR2L = 4'h7;
  localparam logic [3:0] SLOT_FSR2H = 4'h8;
  localparam logic [3:0] SLOT_PRODL = 4'h9;
  localparam logic [3:0] SLOT_PRODH = 4'hA;
  localparam logic [3:0] SLOT_PCLATH = 4'hB;
  localparam logic [3:0] SLOT_PCLATU = 4'hC;
  localparam int unsigned SLOTS = 13;
  // register byte offsets
  localparam logic [7:0] OFF_SHADOW_BASE = 8'h00;
  localparam logic [7:0] OFF_SHADOW_CTRL = 8'h40;
  localparam logic [7:0] OFF_FLAGS = 8'h44;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h48;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h4C;
  localparam logic [7:0] OFF_CONFIG = 8'h50;
  localparam logic [7:0] OFF_STATE = 8'h54;
  localparam logic [7:0] OFF_RAS_TOP = 8'h58;
  // bank of the shadow set as seen by the core
  localparam logic [7:0] SHADOW_BANK = 8'h38;
  // peripheral flag fields
  localparam int unsigned FLAG_TMR4 = 0;
  localparam int unsigned FLAG_CCP2 = 1;
  localparam int unsigned FLAG_CWG2 = 3;
  localparam int unsigned FLAG_CLC2 = 4;
  localparam int unsigned FLAG_INT2 = 5;
  localparam logic [7:0] FLAG_IMPL = 8'h3B;
  // interrupt status bits
  localparam int unsigned EV_ENTRY = 0;
  localparam int unsigned EV_EXIT = 1;
  localparam int unsigned EV_RAS_ERR = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int unsigned CFG_PRIO = 0;
  localparam int unsigned CFG_MVEC = 1;
  localparam int unsigned RAS_DEPTH = 4;
  localparam int unsigned PC_W = 21;

  typedef enum logic [1:0] {
    LVL_MAIN = 2'b00,
    LVL_LOW = 2'b01,
    LVL_HIGH = 2'b11,
    LVL_HIGH_DIRECT = 2'b10
  } level_t;
endpackage

// ===== bench/ctx_checker.sv
// Purpose: port-level checks for the context store
// Assumes: one clock, synchronous active-high reset
// Notes: bound to ctx_save_restore at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module ctx_checker
  import ctx_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic entry_i,
  input wire logic [7:0] vector_i,
  input wire logic [7:0] work_load_o,
  input wire logic work_load_en_o,
  input wire logic exit_i,
  input wire logic restore_o,
  input wire logic [7:0] shadow_bank_o,
  input wire logic [7:0] periph_event_i,
  input wire logic [7:0] flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bad ack");
  a_vector_into_work: assert property (entry_i |=> work_load_en_o && work_load_o == $past(vector_i))
    else $error("vector not loaded");
  a_load_has_entry: assert property (work_load_en_o |-> $past(entry_i)) else $error("stray load");
  a_restore_has_exit: assert property (restore_o |-> $past(exit_i)) else $error("stray restore");
  a_bank_fixed: assert property (shadow_bank_o == 8'h38) else $error("shadow bank wrong");
  a_flag_event_sets: assert property (periph_event_i != 8'h00 |=>
    (flags_o & $past(periph_event_i) & FLAG_IMPL) == ($past(periph_event_i) & FLAG_IMPL)) else $error("flag missed");
  a_flag_unused_zero: assert property ((flags_o & 8'hC4) == 8'h00) else $error("unused flag set");
  a_flag_sticky: assert property (!(cyc_i && stb_i && we_i) |=> ($past(flags_o) & ~flags_o) == 8'h00)
    else $error("flag lost");
  c_entry: cover property (work_load_en_o);
  c_restore: cover property (restore_o);
  c_flags: cover property (flags_o != 8'h00);
  c_nested_exit: cover property (restore_o ##[1:10] restore_o);
endmodule
bind ctx_save_restore ctx_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .entry_i, .vector_i,
  .work_load_o, .work_load_en_o, .exit_i, .restore_o, .shadow_bank_o, .periph_event_i, .flags_o);
`default_nettype wire

// ===== bench/core_model.sv
// Purpose: behavioural processor core facing the context store
// Assumes: bench requests entry, exit and register changes
// Notes: registers are what the core would hold between routines
`timescale 1ns/10ps
`default_nettype none
module core_model
  import ctx_pkg::*;
(
  // bench side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic take_i,
  input wire logic high_i,
  input wire logic ret_i,
  input wire logic [7:0] vec_i,
  input wire logic load_i,
  input wire logic [8*SLOTS-1:0] ctx_new_i,
  // block side
  output logic entry_o,
  output logic entry_high_o,
  output logic [7:0] vector_o,
  output logic [PC_W-1:0] pc_o,
  output logic exit_o,
  output logic [8*SLOTS-1:0] ctx_o,
  input wire logic restore_i,
  input wire logic [8*SLOTS-1:0] restore_ctx_i,
  input wire logic work_load_en_i,
  input wire logic [7:0] work_load_i
);
  always_ff @(posedge clk_i)
  begin
    entry_o <= take_i;
    entry_high_o <= high_i;
    vector_o <= vec_i;
    exit_o <= ret_i;
    pc_o <= rst_i ? 21'h0 : pc_o + 21'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctx_o <= '0;
    else if (restore_i)
      ctx_o <= restore_ctx_i;
    else if (work_load_en_i)
      ctx_o[15:8] <= work_load_i;
    else if (load_i)
      ctx_o <= ctx_new_i;
  end
endmodule
`default_nettype wire

// ===== bench/interrupt_context_save_restore_tb.sv
// Purpose: self-checking bench for the context store
// Assumes: core model on the context port, bench as bus master
// Notes: fixed xorshift seed keeps runs repeatable
`timescale 1ns/10ps
`default_nettype none
module interrupt_context_save_restore_tb
  import ctx_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, exit_i, restore_o, entry_i, entry_high_i, irq_o;
  logic work_load_en_o, take, high, ret, load;
  logic [7:0] adr_i, vector_i, work_load_o, shadow_bank_o, periph_event_i, flags_o, vec, ef;
  logic [3:0] sel_i, sv;
  logic [31:0] dat_i, dat_o, rd, v, w, seed;
  logic [PC_W-1:0] pc_i, ret_pc_o, p0, p1;
  logic [8*SLOTS-1:0] cpu_ctx_i, restore_ctx_o, ctx_new, a, b;
  int err_total, num_checks, cyc_cnt;
  ctx_save_restore dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .entry_i,
    .entry_high_i, .vector_i, .pc_i, .exit_i, .cpu_ctx_i, .restore_ctx_o, .restore_o, .work_load_o,
    .work_load_en_o, .ret_pc_o, .shadow_bank_o, .periph_event_i, .flags_o, .irq_o);
  // entry addresses in delivery order, for the return stack checks
  always @(posedge clk_i)
  begin
    if (entry_i === 1'b1)
    begin
      p1 <= p0;
      p0 <= pc_i;
    end
  end
  core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .take_i(take), .high_i(high), .ret_i(ret), .vec_i(vec),
    .load_i(load), .ctx_new_i(ctx_new), .entry_o(entry_i), .entry_high_o(entry_high_i), .vector_o(vector_i),
    .pc_o(pc_i), .exit_o(exit_i), .ctx_o(cpu_ctx_i), .restore_i(restore_o), .restore_ctx_i(restore_ctx_o),
    .work_load_en_i(work_load_en_o), .work_load_i(work_load_o));
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [103:0] rc();
    logic [127:0] t;
    t = {xs(), xs(), xs(), xs()};
    return t[103:0];
  endfunction
  // flags accumulate only on implemented bits
  function automatic logic [7:0] fexp(input logic [7:0] o, input logic [7:0] e);
    return (o | e) & 8'h3B;
  endfunction
  task automatic chk(input logic [103:0] s, input logic [103:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // waits on ack with no assumed latency; the cycle timeout cuts a hang
  task automatic wb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= wr; adr_i <= ad; dat_i <= d; sel_i <= sv;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ld(input logic [103:0] c);
    load <= 1'b1; ctx_new <= c;
    @(posedge clk_i);
    load <= 1'b0;
    @(posedge clk_i);
  endtask
  // model adds one cycle, the block answers in the next
  task automatic core(input logic t, input logic h, input logic r, input logic [7:0] vv);
    take <= t; high <= h; ret <= r; vec <= vv;
    @(posedge clk_i);
    take <= 1'b0; high <= 1'b0; ret <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    clk_i = 0; rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; sel_i = 0; dat_i = 0; sv = 4'hF;
    take = 0; high = 0; ret = 0; vec = 0; load = 0; ctx_new = 0; periph_event_i = 0; ef = 0; seed = 32'h7C45;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(shadow_bank_o, 8'h38);
    wb(0, OFF_FLAGS, 0); chk(rd, 0);
    wb(0, OFF_CONFIG, 0); chk(rd, 0);
    wb(0, 8'hF0, 0); chk(rd, 0);
    repeat (24)
    begin
      v = xs(); periph_event_i <= v[7:0]; ef = fexp(ef, v[7:0]);
      @(posedge clk_i);
    end
    periph_event_i <= 8'h00;
    @(posedge clk_i);
    chk(flags_o, ef);
    sv = 4'h0; wb(1, OFF_FLAGS, 0); sv = 4'hF;
    wb(0, OFF_FLAGS, 0); chk(rd, ef);
    v = xs(); wb(1, OFF_FLAGS, v); ef = ef & v[7:0];
    wb(0, OFF_FLAGS, 0); chk(rd, ef);
    wb(1, OFF_FLAGS, 0);
    for (int k = 0; k < 2; k++)
    begin
      wb(1, OFF_CONFIG, k ? 32'h3 : 32'h1);
      wb(1, OFF_IRQ_STATUS, 32'h7); chk(irq_o, 0);
      wb(1, OFF_IRQ_MASK, k ? 32'h0 : 32'h1);
      a = rc(); b = rc(); w = xs(); v = xs();
      ld(a); core(1, 0, 0, v[7:0]); chk(cpu_ctx_i[15:8], v[7:0]);
      chk(irq_o, k ? 0 : 1);
      ld(b); core(1, 1, 0, v[15:8]);
      wb(0, OFF_STATE, 0); chk(rd, 8'h0B);
      wb(0, OFF_RAS_TOP, 0); chk(rd, p0);
      for (int j = 0; j < 2; j++)
      begin
        wb(1, OFF_SHADOW_CTRL, j);
        for (int i = 0; i < 13; i++)
        begin
          wb(0, 4 * i, 0); chk(rd[7:0], j ? b[8*i+:8] : a[8*i+:8]);
        end
      end
      wb(1, 8'h08, w); b[23:16] = w[7:0];
      core(0, 0, 1, 0); chk(cpu_ctx_i, b);
      chk(ret_pc_o, p0);
      core(0, 0, 1, 0); chk(cpu_ctx_i, a);
      chk(ret_pc_o, p1);
    end
    wb(1, OFF_CONFIG, 0);
    ld(a); core(1, 0, 0, 8'h11);
    ld(~b); core(1, 1, 0, 8'h22);
    wb(0, OFF_STATE, 0); chk(rd, 8'h05);
    wb(0, 8'h0C, 0); chk(rd[7:0], b[31:24]);
    core(0, 0, 1, 0); chk(cpu_ctx_i, a);
    close_out();
  end
endmodule
`default_nettype wire
